// ===== hdl/fault_supervisor.sv
// Protection and fault reporting core of the motor driver
`timescale 1ns/10ps
module fault_supervisor #(
  parameter int LOCK_OFF_CYC = supervisor_pkg::LOCK_OFF_CYC,
  parameter int MEAS_W       = 12
) (
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  // Serial register port
  input  wire logic              I_SCL,
  input  wire logic              I_SDA,
  output logic                   O_SDA_O,
  output logic                   O_SDA_OE,
  // Thermal monitors
  input  wire logic              I_TEMP_SDN,
  input  wire logic              I_TEMP_RECOVER,
  input  wire logic              I_TEMP_WARN,
  // Supply monitors
  input  wire logic              I_VCC_BELOW_FALL,
  input  wire logic              I_VCC_ABOVE_RISE,
  input  wire logic              I_BUCK_UV,
  input  wire logic              I_CPUMP_UV,
  input  wire logic              I_V3P3_UV,
  // Current and lock detection
  input  wire logic              I_OVERCURRENT,
  input  wire logic [5:0]        I_LOCK_DET,
  // Measurements
  input  wire logic [MEAS_W-1:0] I_PHASE_CURR,
  input  wire logic [MEAS_W-1:0] I_VCC_MEAS,
  input  wire logic              I_MEAS_VALID,
  // Stored settings
  input  wire logic              I_SLEEP_EXIT,
  input  wire logic [15:0]       I_NV_DATA,
  output logic                   O_NV_RD,
  // Motor side
  input  wire logic              I_DIR,
  input  wire logic              I_COMMUTATE,
  output logic                   O_DIR,
  output logic                   O_TACH,
  output logic                   O_DRIVE_EN,
  output logic                   O_HIZ
);
  localparam int CW = $clog2(LOCK_OFF_CYC + 1);

  reg_if rb ();

  serial_slave u_serial (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_scl    (I_SCL),
    .i_sda    (I_SDA),
    .o_sda_o  (O_SDA_O),
    .o_sda_oe (O_SDA_OE),
    .rb       (rb)
  );

  supervisor_pkg::prot_t pst_q, pst_d;
  supervisor_pkg::load_t lst_q, lst_d;
  logic [CW-1:0]     cnt_q, cnt_d;
  logic              hiz_q, hiz_d, sdn_q, sdn_d, uv_q, uv_d, tach_q, tach_d, dir_q;
  logic [15:0]       flags_q, flags_d, host_q, host_d, nv_q, nv_d, eff;
  logic [MEAS_W-1:0] curr_q, volt_q;
  logic [5:0]        lock_hit;
  logic              aux_uv, fault_rd;

  // ==========================================================================
  // Effective settings and lock sources
  assign eff      = host_q[supervisor_pkg::REG_MODE_BIT] ? host_q : nv_q;
  assign lock_hit = I_LOCK_DET & eff[supervisor_pkg::LOCK_BITS-1:0];
  assign aux_uv   = I_BUCK_UV | I_CPUMP_UV | I_V3P3_UV;
  assign fault_rd = rb.rd && rb.addr == supervisor_pkg::FAULT_OFS;

  // ==========================================================================
  // Thermal, supply and fault flags
  always_comb begin
    sdn_d = sdn_q;
    if (I_TEMP_SDN) sdn_d = 1'b1;
    else if (I_TEMP_RECOVER) sdn_d = 1'b0;
    uv_d = uv_q;
    if (I_VCC_BELOW_FALL || aux_uv) uv_d = 1'b1;
    else if (I_VCC_ABOVE_RISE) uv_d = 1'b0;
    flags_d = fault_rd ? supervisor_pkg::FAULT_RST : flags_q;
    if (sdn_q) flags_d[supervisor_pkg::OVERHEAT_BIT] = 1'b1;
    if (I_TEMP_WARN) flags_d[supervisor_pkg::WARN_BIT] = 1'b1;
    if (uv_q) flags_d[supervisor_pkg::UNDERVOLT_BIT] = 1'b1;
    if (I_OVERCURRENT) flags_d[supervisor_pkg::EXCESS_CURRENT_FLAG_BIT] = 1'b1;
    flags_d[supervisor_pkg::LOCK_BITS-1:0] =
      flags_d[supervisor_pkg::LOCK_BITS-1:0] | lock_hit;
    tach_d = I_COMMUTATE ? ~tach_q : tach_q;
  end

  // ==========================================================================
  // Lock and overcurrent protection cycle
  always_comb begin
    pst_d = pst_q;
    cnt_d = cnt_q;
    hiz_d = hiz_q;
    unique case (pst_q)
      supervisor_pkg::P_RUN: if (|lock_hit || I_OVERCURRENT || hiz_q) begin
        // A current fault in the last hold cycle starts a fresh hold
        pst_d = supervisor_pkg::P_HOLD;
        cnt_d = '0;
        hiz_d = I_OVERCURRENT | hiz_q;
      end
      supervisor_pkg::P_HOLD: begin
        if (cnt_q == CW'(LOCK_OFF_CYC - 1)) begin
          pst_d = supervisor_pkg::P_RUN;
          hiz_d = 1'b0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
        if (I_OVERCURRENT) hiz_d = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Stored settings load and host writes
  always_comb begin
    lst_d  = (I_SLEEP_EXIT) ? supervisor_pkg::L_READ : supervisor_pkg::L_IDLE;
    nv_d   = (lst_q == supervisor_pkg::L_READ) ? I_NV_DATA : nv_q;
    host_d = host_q;
    if (rb.wr && rb.addr == supervisor_pkg::CTRL_OFS) host_d = rb.wdata;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pst_q   <= supervisor_pkg::P_RUN;
      cnt_q   <= '0;
      hiz_q   <= 1'b0;
      lst_q   <= supervisor_pkg::L_READ;
      nv_q    <= supervisor_pkg::CTRL_RST;
      host_q  <= supervisor_pkg::CTRL_RST & ~16'h8000;
      flags_q <= supervisor_pkg::FAULT_RST;
      sdn_q   <= 1'b0;
      uv_q    <= 1'b1;
      tach_q  <= 1'b0;
      dir_q   <= 1'b0;
      curr_q  <= '0;
      volt_q  <= '0;
    end else begin
      pst_q   <= pst_d;
      cnt_q   <= cnt_d;
      hiz_q   <= hiz_d;
      lst_q   <= lst_d;
      nv_q    <= nv_d;
      host_q  <= host_d;
      flags_q <= flags_d;
      sdn_q   <= sdn_d;
      uv_q    <= uv_d;
      tach_q  <= tach_d;
      dir_q   <= I_DIR;
      if (I_MEAS_VALID) begin
        curr_q <= I_PHASE_CURR;
        volt_q <= I_VCC_MEAS;
      end
    end
  end

  // ==========================================================================
  // Register read mux
  always_comb begin
    unique case (rb.addr)
      supervisor_pkg::FAULT_OFS: rb.rdata = flags_q;
      supervisor_pkg::CURR_OFS:  rb.rdata = 16'(curr_q);
      supervisor_pkg::VOLT_OFS:  rb.rdata = 16'(volt_q);
      supervisor_pkg::CTRL_OFS:  rb.rdata = host_q;
      supervisor_pkg::EFF_OFS:   rb.rdata = eff;
      default:                   rb.rdata = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Outputs
  assign O_NV_RD    = (lst_q == supervisor_pkg::L_READ);
  assign O_DRIVE_EN = (pst_q == supervisor_pkg::P_RUN) & ~sdn_q & ~uv_q &
                      ~(|lock_hit) & ~I_OVERCURRENT & ~hiz_q;
  assign O_HIZ      = hiz_q | I_OVERCURRENT;
  assign O_TACH     = tach_q;
  assign O_DIR      = dir_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence lock_seen;
    (pst_q == supervisor_pkg::P_RUN) && |lock_hit && !I_OVERCURRENT;
  endsequence
  sequence hold_entered;
    ##1 (pst_q == supervisor_pkg::P_HOLD) && (cnt_q == '0) && !O_DRIVE_EN;
  endsequence

  lock_stop_a : assert property (|lock_hit |-> !O_DRIVE_EN)
    else $error("drive active during lock");
  lock_hold_a : assert property (lock_seen |-> hold_entered)
    else $error("lock did not start hold");
  release_end_a : assert property ((pst_q == supervisor_pkg::P_HOLD) &&
    cnt_q == CW'(LOCK_OFF_CYC - 1) |=> pst_q == supervisor_pkg::P_RUN)
    else $error("no restart after release time");
  hold_count_a : assert property ((pst_q == supervisor_pkg::P_HOLD) &&
    cnt_q != CW'(LOCK_OFF_CYC - 1) |=> pst_q == supervisor_pkg::P_HOLD &&
    cnt_q == $past(cnt_q) + CW'(1))
    else $error("release counter misstepped");
  oc_hiz_a : assert property (I_OVERCURRENT |=> hiz_q && flags_q[11] && !O_DRIVE_EN)
    else $error("overcurrent not handled");
  heat_stop_a : assert property (I_TEMP_SDN |=> sdn_q ##1 flags_q[15] && !O_DRIVE_EN)
    else $error("thermal shutdown not handled");
  sdn_flag_a : assert property (sdn_q |=> flags_q[15])
    else $error("overheat flag not held");
  warn_flag_a : assert property (I_TEMP_WARN |=> flags_q[14])
    else $error("warning flag not set");
  uv_lock_a : assert property ((I_VCC_BELOW_FALL || aux_uv) |=> uv_q ##0 !O_DRIVE_EN)
    else $error("undervoltage lockout missing");
  flag_keep_a : assert property (flags_q[11] && !fault_rd |=> flags_q[11])
    else $error("fault flag lost before read");
  lock_src_a : assert property (lock_hit[0] |=> flags_q[0])
    else $error("lock method not reported");
  nv_load_a : assert property (I_SLEEP_EXIT |=> O_NV_RD ##1 nv_q == $past(I_NV_DATA))
    else $error("stored settings not loaded");
  tach_a : assert property (I_COMMUTATE |=> O_TACH != $past(O_TACH))
    else $error("tach did not toggle");
endmodule // fault_supervisor

// ===== hdl/supervisor_pkg.sv
// Constants, register map and types of the motor fault supervisor
package supervisor_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int LOCK_OFF_S    = 5;
  localparam int LOCK_OFF_CYC  = LOCK_OFF_S * CLK_HZ;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] FAULT_OFS   = 8'h00;
  localparam logic [7:0] CURR_OFS    = 8'h01;
  localparam logic [7:0] VOLT_OFS    = 8'h02;
  localparam logic [7:0] CTRL_OFS    = 8'h03;
  localparam logic [7:0] EFF_OFS     = 8'h04;

  // ==========================================================================
  // Field positions and reset values
  localparam int OVERHEAT_BIT  = 15;
  localparam int WARN_BIT      = 14;
  localparam int UNDERVOLT_BIT = 13;
  localparam int EXCESS_CURRENT_FLAG_BIT  = 11;
  localparam int LOCK_BITS     = 6;
  localparam int REG_MODE_BIT  = 15;
  localparam logic [15:0] CTRL_RST  = 16'h003F;
  localparam logic [15:0] FAULT_RST = 16'h0000;
  localparam logic [6:0]  DEV_ADDR  = 7'h52;  // Arbitrary value

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {
    P_RUN  = 1'b0,
    P_HOLD = 1'b1
  } prot_t;

  typedef enum logic [0:0] {
    L_IDLE = 1'b0,
    L_READ = 1'b1
  } load_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX   = 3'b001,
    S_ACK  = 3'b010,
    S_TX   = 3'b011,
    S_MACK = 3'b100
  } ser_t;

endpackage

// ===== hdl/reg_if.sv
// Register access carrier between the serial slave and the supervisor core
`timescale 1ns/10ps
interface reg_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        wr;
  logic        rd;
  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave  (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ===== hdl/serial_slave.sv
// Two-wire serial register slave with 8-bit pointer and 16-bit words
`timescale 1ns/10ps
module serial_slave (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Serial pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  // Register side
  reg_if.master     rb
);
  supervisor_pkg::ser_t st_q, st_d;
  logic       scl_q, sda_q, nack_q, nack_d, rw_q, rw_d, lo_q, lo_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, hi_q, hi_d;
  logic [15:0] tx_q, tx_d;
  logic       rise, fall, start, stop;

  assign rise  = i_scl & ~scl_q;
  assign fall  = ~i_scl & scl_q;
  assign start = i_scl & scl_q & sda_q & ~i_sda;
  assign stop  = i_scl & scl_q & ~sda_q & i_sda;

  // ==========================================================================
  // Protocol engine
  always_comb begin
    st_d = st_q; ph_d = ph_q; cnt_d = cnt_q; sh_d = sh_q; ptr_d = ptr_q;
    hi_d = hi_q; tx_d = tx_q; rw_d = rw_q; lo_d = lo_q; nack_d = nack_q;
    rb.wr = 1'b0; rb.rd = 1'b0; rb.addr = ptr_q; rb.wdata = {hi_q, sh_q};
    if (start) begin
      st_d = supervisor_pkg::S_RX; ph_d = 2'd0; cnt_d = 4'h0;
    end else if (stop) begin
      st_d = supervisor_pkg::S_IDLE;
    end else begin
      unique case (st_q)
        supervisor_pkg::S_IDLE: ;
        supervisor_pkg::S_RX: begin
          if (rise) begin
            sh_d = {sh_q[6:0], i_sda}; cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            st_d = supervisor_pkg::S_ACK;
            unique case (ph_q)
              2'd0: begin
                rw_d = sh_q[0];
                if (sh_q[7:1] != supervisor_pkg::DEV_ADDR) st_d = supervisor_pkg::S_IDLE;
              end
              2'd1: ptr_d = sh_q;
              2'd2: hi_d = sh_q;
              2'd3: begin
                rb.wr = 1'b1; ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        supervisor_pkg::S_ACK: if (fall) begin
          cnt_d = 4'h0;
          if (ph_q == 2'd0 && rw_q) begin
            rb.rd = 1'b1; tx_d = rb.rdata; lo_d = 1'b0;
            st_d = supervisor_pkg::S_TX;
          end else begin
            ph_d = (ph_q == 2'd3) ? 2'd2 : ph_q + 2'd1;
            st_d = supervisor_pkg::S_RX;
          end
        end
        supervisor_pkg::S_TX: begin
          if (rise) cnt_d = cnt_q + 4'h1;
          else if (fall) begin
            if (cnt_q == 4'h8) st_d = supervisor_pkg::S_MACK;
            else tx_d = {tx_q[14:0], 1'b0};
          end
        end
        supervisor_pkg::S_MACK: begin
          if (rise) nack_d = i_sda;
          else if (fall) begin
            cnt_d = 4'h0;
            if (nack_q) st_d = supervisor_pkg::S_IDLE;
            else begin
              st_d = supervisor_pkg::S_TX;
              lo_d = ~lo_q;
              if (lo_q) begin
                ptr_d = ptr_q + 8'h01;
                rb.addr = ptr_q + 8'h01;
                rb.rd = 1'b1; tx_d = rb.rdata;
              // Low byte waits in bits 14:7, the eighth fall does not shift
              end else tx_d = {tx_q[14:7], 8'h00};
            end
          end
        end
        default: st_d = supervisor_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= supervisor_pkg::S_IDLE; ph_q <= 2'd0; cnt_q <= 4'h0; sh_q <= 8'h00;
      ptr_q <= 8'h00; hi_q <= 8'h00; tx_q <= 16'h0000; rw_q <= 1'b0; lo_q <= 1'b0;
      nack_q <= 1'b1; scl_q <= 1'b1; sda_q <= 1'b1;
    end else begin
      st_q <= st_d; ph_q <= ph_d; cnt_q <= cnt_d; sh_q <= sh_d; ptr_q <= ptr_d;
      hi_q <= hi_d; tx_q <= tx_d; rw_q <= rw_d; lo_q <= lo_d; nack_q <= nack_d;
      scl_q <= i_scl; sda_q <= i_sda;
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = (st_q == supervisor_pkg::S_ACK) |
                    (st_q == supervisor_pkg::S_TX && !tx_q[15]);

  // ==========================================================================
  // Checks
  ack_low_a : assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == supervisor_pkg::S_RX) && fall && (cnt_q == 4'h8) &&
    (ph_q != 2'd0 || sh_q[7:1] == supervisor_pkg::DEV_ADDR) |=> o_sda_oe && !o_sda_o)
    else $error("ack bit not driven low");
  write_step_a : assert property (@(posedge i_clk) disable iff (i_rst)
    rb.wr |=> (ptr_q == $past(ptr_q) + 8'h01))
    else $error("pointer did not advance after write");
endmodule // serial_slave

// ===== testbench/host_model.sv
// Host controller model driving the two-wire register port
`timescale 1ns/10ps
module host_model #(
  parameter int Q = 4
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda
);
  // ==========================================================================
  // Wire primitives, released SDA reads back through the pull-up
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda = 1'b1;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda = 1'b0;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask
  task automatic stop();
    sda = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda = 1'b1;
    hold(Q);
  endtask
  task automatic xbit(input logic b, output logic r);
    sda = b;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    r = sda_in;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask
  // ==========================================================================
  // Bytes and words, most significant bit first
  task automatic wbyte(input logic [7:0] v, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(v[i], r);
    xbit(1'b1, nack);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, v[i]);
    xbit(last, r);
  endtask
  task automatic wr_word(input logic [7:0] ofs, input logic [15:0] v, output logic [3:0] nk);
    start();
    wbyte({supervisor_pkg::DEV_ADDR, 1'b0}, nk[3]);
    wbyte(ofs, nk[2]);
    wbyte(v[15:8], nk[1]);
    wbyte(v[7:0], nk[0]);
    stop();
  endtask
  task automatic rd_word(input logic [7:0] ofs, output logic [15:0] v, output logic [2:0] nk);
    start();
    wbyte({supervisor_pkg::DEV_ADDR, 1'b0}, nk[2]);
    wbyte(ofs, nk[1]);
    start();
    wbyte({supervisor_pkg::DEV_ADDR, 1'b1}, nk[0]);
    rbyte(1'b0, v[15:8]);
    rbyte(1'b1, v[7:0]);
    stop();
  endtask
endmodule  // host_model

// ===== testbench/fault_supervisor_bench.sv
// Self-checking bench for the motor fault supervisor
`timescale 1ns/10ps
module fault_supervisor_bench;
  // ==========================================================================
  // Signals
  localparam int LOCK_CYC = 20;
  localparam logic [15:0] NV0 = 16'h0A3F;
  localparam logic [15:0] NV1 = 16'h053F;
  logic        clk, rst, scl, host_sda, sda_o, sda_oe, nv_rd, dir_o, tach, drive_en, hiz;
  logic        temp_sdn, temp_rec, temp_warn, vcc_fall, vcc_rise, buck_uv, cpump_uv, v3p3_uv;
  logic        oc, meas_valid, sleep_exit, dir, commutate;
  logic [5:0]  lock_det;
  logic [11:0] phase_curr, vcc_meas;
  logic [15:0] nv_data, junk;
  logic [2:0]  nk;
  wire         sda_line = host_sda & (sda_oe ? sda_o : 1'b1);
  int          err_total, cmp_count;

  host_model host (.clk(clk), .sda_in(sda_line), .scl(scl), .sda(host_sda));
  fault_supervisor #(.LOCK_OFF_CYC(LOCK_CYC), .MEAS_W(12)) uut (
    .I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_line), .O_SDA_O(sda_o),
    .O_SDA_OE(sda_oe), .I_TEMP_SDN(temp_sdn), .I_TEMP_RECOVER(temp_rec),
    .I_TEMP_WARN(temp_warn), .I_VCC_BELOW_FALL(vcc_fall), .I_VCC_ABOVE_RISE(vcc_rise),
    .I_BUCK_UV(buck_uv), .I_CPUMP_UV(cpump_uv), .I_V3P3_UV(v3p3_uv), .I_OVERCURRENT(oc),
    .I_LOCK_DET(lock_det), .I_PHASE_CURR(phase_curr), .I_VCC_MEAS(vcc_meas),
    .I_MEAS_VALID(meas_valid), .I_SLEEP_EXIT(sleep_exit), .I_NV_DATA(nv_data),
    .O_NV_RD(nv_rd), .I_DIR(dir), .I_COMMUTATE(commutate), .O_DIR(dir_o), .O_TACH(tach),
    .O_DRIVE_EN(drive_en), .O_HIZ(hiz));

  // ==========================================================================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [15:0] exp, input string what);
    logic [15:0] v;
    logic [2:0]  a;
    host.rd_word(ofs, v, a);
    chk({13'h0, a}, 16'h0000, "read ack");
    chk(v, exp, what);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [15:0] v);
    logic [3:0] a;
    host.wr_word(ofs, v, a);
    chk({12'h0, a}, 16'h0000, "write ack");
  endtask
  task automatic drive_is(input logic exp, input string what);
    chk({15'h0, drive_en}, {15'h0, exp}, what);
  endtask
  task automatic prot_event(input logic is_oc, input logic [5:0] lk);
    int n;
    int z;
    n = 0;
    z = 0;
    oc = is_oc;
    lock_det = lk;
    #1;
    chk({14'h0, drive_en, hiz}, {15'h0, is_oc}, "immediate stop");
    tick(1);
    oc = 1'b0;
    lock_det = 6'h00;
    while (drive_en !== 1'b1 && n < 100) begin
      z += (hiz === 1'b1);
      n++;
      tick(1);
    end
    chk({15'h0, n >= LOCK_CYC - 1 && n <= LOCK_CYC + 1}, 16'h0001, "hold span");
    chk(z[15:0], is_oc ? n[15:0] : 16'h0000, "hiz span");
    chk({15'h0, hiz}, 16'h0000, "hiz after hold");
    rd(supervisor_pkg::FAULT_OFS, is_oc ? 16'h0800 : {10'h0, lk}, "event flags");
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_total++;
    final_report();
  end

  // ==========================================================================
  // Tests
  initial begin
    {rst, temp_sdn, temp_warn, vcc_fall, buck_uv, cpump_uv, v3p3_uv, oc} = 8'h80;
    {temp_rec, vcc_rise, meas_valid, sleep_exit, dir, commutate} = 6'h30;
    lock_det = 6'h00;
    phase_curr = 12'h000;
    vcc_meas = 12'h000;
    nv_data = NV0;
    repeat (3) @(posedge clk);
    chk({14'h0, drive_en, nv_rd}, 16'h0001, "in reset");
    #1 rst = 1'b0;
    tick(2);
    drive_is(1'b1, "after reset");
    host.rd_word(supervisor_pkg::FAULT_OFS, junk, nk);
    rd(supervisor_pkg::CTRL_OFS, supervisor_pkg::CTRL_RST, "ctrl reset");
    rd(supervisor_pkg::EFF_OFS, NV0, "power-on load");
    vcc_rise = 1'b0;
    vcc_fall = 1'b1;
    tick(2);
    drive_is(1'b0, "uv lock");
    vcc_fall = 1'b0;
    tick(4);
    drive_is(1'b0, "uv hysteresis");
    vcc_rise = 1'b1;
    tick(2);
    drive_is(1'b1, "uv release");
    for (int i = 0; i < 3; i++) begin
      {buck_uv, cpump_uv, v3p3_uv} = 3'b100 >> i;
      tick(2);
      drive_is(1'b0, "aux uv lock");
      {buck_uv, cpump_uv, v3p3_uv} = 3'b000;
      tick(2);
      drive_is(1'b1, "aux uv release");
    end
    rd(supervisor_pkg::FAULT_OFS, 16'h2000, "uv flag");
    {temp_sdn, temp_rec} = 2'b10;
    tick(2);
    drive_is(1'b0, "thermal stop");
    rd(supervisor_pkg::FAULT_OFS, 16'h8000, "overheat flag");
    temp_sdn = 1'b0;
    tick(4);
    drive_is(1'b0, "thermal hysteresis");
    rd(supervisor_pkg::FAULT_OFS, 16'h8000, "overheat held");
    temp_rec = 1'b1;
    tick(2);
    drive_is(1'b1, "thermal resume");
    rd(supervisor_pkg::FAULT_OFS, 16'h8000, "overheat sticky");
    temp_warn = 1'b1;
    rd(supervisor_pkg::FAULT_OFS, 16'h4000, "warning flag");
    drive_is(1'b1, "warning keeps drive");
    temp_warn = 1'b0;
    rd(supervisor_pkg::FAULT_OFS, 16'h4000, "warning sticky");
    rd(supervisor_pkg::FAULT_OFS, 16'h0000, "cleared by read");
    prot_event(1'b1, 6'h00);
    for (int k = 0; k < 6; k++) prot_event(1'b0, 6'h01 << k);
    phase_curr = 12'hABC;
    vcc_meas = 12'h5A1;
    meas_valid = 1'b1;
    tick(1);
    {meas_valid, phase_curr, vcc_meas} = {1'b0, 24'h123456};
    rd(supervisor_pkg::CURR_OFS, 16'h0ABC, "phase current");
    rd(supervisor_pkg::VOLT_OFS, 16'h05A1, "supply voltage");
    nv_data = NV1;
    sleep_exit = 1'b1;
    tick(1);
    chk({15'h0, nv_rd}, 16'h0001, "sleep exit load strobe");
    sleep_exit = 1'b0;
    tick(3);
    rd(supervisor_pkg::EFF_OFS, NV1, "sleep exit load");
    wr(supervisor_pkg::CTRL_OFS, 16'h8015);
    wr(supervisor_pkg::EFF_OFS, 16'h1234);
    rd(supervisor_pkg::EFF_OFS, 16'h8015, "register mode");
    rd(8'h10, 16'h0000, "unmapped");
    lock_det = 6'h02;
    #1;
    drive_is(1'b1, "disabled method");
    tick(1);
    lock_det = 6'h00;
    host.start();
    host.wbyte(8'h54, nk[0]);
    host.stop();
    chk({15'h0, nk[0]}, 16'h0001, "foreign address");
    dir = 1'b1;
    tick(2);
    chk({15'h0, dir_o}, 16'h0001, "direction");
    for (int i = 1; i <= 3; i++) begin
      commutate = 1'b1;
      tick(1);
      commutate = 1'b0;
      tick(1);
      chk({15'h0, tach}, {15'h0, i[0]}, "tach toggle");
    end
    final_report();
  end
endmodule  // fault_supervisor_bench
